// file: hw/mmr_core.sv
`timescale 1ns/10ps
`default_nettype none
module mmr_core #(
   parameter logic [31:0] REVISION_ID    = mmr_pkg::REVISION_BASE,
   parameter bit          LOCK_SUPPORTED = 1'b1
) (
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  sys_rst,
   // processor state from the core
   input  wire logic                  mgmt_interrupt,
   input  wire logic                  cpu_halted,
   input  wire mmr_pkg::mmr_io_info_s io_info,
   input  wire mmr_pkg::mmr_io_regs_s io_regs,
   input  wire logic                  resume_instr,
   // sequencing results
   output logic                       mgmt_mode,
   output logic                       entry_pulse,
   output logic                       resume_done,
   output logic                       resume_halt,
   output logic                       io_reexec,
   output logic                       halt_cycle,
   // save-area access from the handler
   input  wire mmr_pkg::mmr_sa_req_s  sa_req,
   output logic [63:0]                sa_rdata,
   output logic                       sa_rvalid,
   // configuration and fault path
   input  wire logic                  hwcfg_wr,
   input  wire logic [63:0]           hwcfg_wdata,
   input  wire logic                  ext_feature_reg_wr,
   input  wire logic                  cr_wr,
   input  wire logic [3:0]            cr_index,
   input  wire logic                  fp_exc,
   input  wire logic                  fp_masked,
   output logic                       paging_cfg_lock,
   output logic                       general_protection_fault,
   output logic                       fp_fault,
   output logic                       paging_lock_support
);
   import mmr_pkg::*;

   mmr_state_e   state_q, state_d;
   logic         pend_q, pend_d;
   logic [7:0]   io_restart_q, io_restart_d;
   logic [7:0]   auto_halt_q, auto_halt_d;
   logic         res_halt_q, res_halt_d;
   logic         reexec_q, reexec_d;
   logic         halt_cyc_q, halt_cyc_d;
   logic [63:0]  rdata_q, rdata_d;
   logic         rvalid_q, rvalid_d;
   logic         take;
   logic         do_resume;
   logic         handler_wr;
   logic         in_mode;
   logic [31:0]  info_dword;
   logic [31:0]  revision;
   mmr_io_regs_s saved_regs;

   // mode sequencing
   always_comb begin
      take      = (state_q == ST_RUN) && (mgmt_interrupt || pend_q);
      do_resume = (state_q == ST_INMODE) && resume_instr;
      state_d   = state_q;
      unique case (state_q)
         ST_RUN: begin
            if (take)
               state_d = ST_ENTER;
         end
         ST_ENTER: begin
            state_d = ST_INMODE;
         end
         ST_INMODE: begin
            if (resume_instr)
               state_d = ST_EXIT;
         end
         ST_EXIT: begin
            state_d = ST_RUN;
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
      // latched while busy, taken once back in run
      pend_d = (mgmt_interrupt && (state_q != ST_RUN)) ||
               (pend_q && (state_q != ST_RUN));
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_q <= ST_RUN;
         pend_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         pend_q  <= pend_d;
      end
   end

   // save-area bytes and resume decisions
   always_comb begin
      in_mode      = (state_q == ST_ENTER) || (state_q == ST_INMODE);
      handler_wr   = sa_req.valid && sa_req.write && (state_q == ST_INMODE);
      io_restart_d = io_restart_q;
      auto_halt_d  = auto_halt_q;
      res_halt_d   = res_halt_q;
      reexec_d     = reexec_q;
      if (take) begin
         io_restart_d = IO_RESTART_CLEAR;
         auto_halt_d  = {7'h00, cpu_halted};
      end else if (handler_wr) begin
         if (sa_req.addr == OFS_IO_RESTART)
            io_restart_d = sa_req.wdata;
         if (sa_req.addr == OFS_AUTO_HALT)
            auto_halt_d = sa_req.wdata;
      end
      if (do_resume) begin
         // any nonzero value halts, even after a running entry
         res_halt_d = (auto_halt_q != AUTO_HALT_CLEAR);
         reexec_d   = (io_restart_q != IO_RESTART_CLEAR);
      end
      // halt is signalled on the bus, never re-executed
      halt_cyc_d = (state_q == ST_EXIT) && res_halt_q;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         io_restart_q <= IO_RESTART_CLEAR;
         auto_halt_q  <= AUTO_HALT_CLEAR;
         res_halt_q   <= 1'b0;
         reexec_q     <= 1'b0;
         halt_cyc_q   <= 1'b0;
      end else begin
         io_restart_q <= io_restart_d;
         auto_halt_q  <= auto_halt_d;
         res_halt_q   <= res_halt_d;
         reexec_q     <= reexec_d;
         halt_cyc_q   <= halt_cyc_d;
      end
   end

   // handler read port, one cycle latency
   always_comb begin
      revision = REVISION_ID;
      revision[REV_IO_RESTART_BIT] = 1'b1;
      rdata_d  = '0;
      rvalid_d = sa_req.valid && !sa_req.write;
      if (rvalid_d) begin
         unique case (sa_req.addr)
            OFS_IO_RESTART: rdata_d = {56'h0, io_restart_q};
            OFS_AUTO_HALT:  rdata_d = {56'h0, auto_halt_q};
            OFS_IO_INFO:    rdata_d = {32'h0, info_dword};
            OFS_IO_IP:      rdata_d = saved_regs.ip;
            OFS_IO_COUNT:   rdata_d = saved_regs.count;
            OFS_IO_SRC:     rdata_d = saved_regs.src;
            OFS_IO_DST:     rdata_d = saved_regs.dst;
            OFS_REVISION:   rdata_d = {32'h0, revision};
            default:        rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rdata_q  <= '0;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // only the io context is captured; wide media, fp and misc state stay with software
   mmr_io_capture u_capture (
      .mclk       (mclk),
      .sys_rst    (sys_rst),
      .capture    (take),
      .info       (io_info),
      .regs_in    (io_regs),
      .info_dword (info_dword),
      .regs_out   (saved_regs)
   );

   mmr_paging_lock #(
      .LOCK_SUPPORTED (LOCK_SUPPORTED)
   ) u_lock (
      .mclk           (mclk),
      .sys_rst        (sys_rst),
      .in_mode        (in_mode),
      .resume_done    (state_q == ST_EXIT),
      .hwcfg_wr       (hwcfg_wr),
      .hwcfg_wdata    (hwcfg_wdata),
      .ext_feature_reg_wr        (ext_feature_reg_wr),
      .cr_wr          (cr_wr),
      .cr_index       (cr_index),
      .fp_exc         (fp_exc),
      .fp_masked      (fp_masked),
      .lock           (paging_cfg_lock),
      .gp_fault       (general_protection_fault),
      .fp_fault       (fp_fault),
      .ident_lock_bit (paging_lock_support)
   );

   assign mgmt_mode   = in_mode || (state_q == ST_EXIT);
   assign entry_pulse = (state_q == ST_ENTER);
   assign resume_done = (state_q == ST_EXIT);
   assign resume_halt = res_halt_q;
   assign io_reexec   = reexec_q;
   assign halt_cycle  = halt_cyc_q;
   assign sa_rdata    = rdata_q;
   assign sa_rvalid   = rvalid_q;

   sequence resume_seq;
      (state_q == ST_INMODE) && resume_instr ##1 resume_done;
   endsequence

   entry_io_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
      take |=> entry_pulse && (io_restart_q == 8'h00))
      else $error("io restart byte not cleared at entry");

   entry_halt_bit_a: assert property (@(posedge mclk) disable iff (sys_rst)
      take |=> (auto_halt_q == {7'h00, $past(cpu_halted)}))
      else $error("auto-halt byte wrong at entry");

   resume_halt_a: assert property (@(posedge mclk) disable iff (sys_rst)
      resume_seq |-> (resume_halt == ($past(auto_halt_q) != 8'h00)))
      else $error("resume halt decision wrong");

   halt_cycle_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (resume_done && resume_halt) |=> halt_cycle ##1 !halt_cycle)
      else $error("halt bus cycle missing after resume");

   io_reexec_a: assert property (@(posedge mclk) disable iff (sys_rst)
      resume_seq |-> (io_reexec == ($past(io_restart_q) != 8'h00)))
      else $error("io re-execute decision wrong");

   no_reentry_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (state_q == ST_INMODE) && mgmt_interrupt |=> pend_q && !entry_pulse)
      else $error("interrupt not latched inside mode");

   pend_taken_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (pend_q && resume_done) |-> ##2 entry_pulse)
      else $error("latched interrupt not taken after exit");

   rev_bit_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (sa_req.valid && !sa_req.write && sa_req.addr == OFS_REVISION) |=> sa_rvalid && sa_rdata[16])
      else $error("revision restart bit not set");

   sequence halt_byte_wr_seq;
      handler_wr && (sa_req.addr == OFS_AUTO_HALT);
   endsequence

   sequence io_byte_wr_seq;
      handler_wr && (sa_req.addr == OFS_IO_RESTART);
   endsequence

   halt_byte_wr_a: assert property (@(posedge mclk) disable iff (sys_rst)
      halt_byte_wr_seq |=> (auto_halt_q == $past(sa_req.wdata)))
      else $error("handler write of auto-halt byte lost");

   io_byte_wr_a: assert property (@(posedge mclk) disable iff (sys_rst)
      io_byte_wr_seq |=> (io_restart_q == $past(sa_req.wdata)))
      else $error("handler write of io restart byte lost");

   idle_wr_drop_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (sa_req.valid && sa_req.write && (state_q != ST_INMODE) && !take)
         |=> $stable(auto_halt_q) && $stable(io_restart_q))
      else $error("save-area write taken outside handler");

   read_answer_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (sa_req.valid && !sa_req.write) |=> sa_rvalid)
      else $error("save-area read not answered");

   halt_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (resume_done && !resume_halt) |=> !halt_cycle)
      else $error("halt bus cycle without halt resume");

endmodule // mmr_core
`default_nettype wire

// file: hw/mmr_pkg.sv
`default_nettype none
package mmr_pkg;

   // save-area byte offsets
   localparam logic [15:0] OFS_IO_RESTART = 16'hFEC8;
   localparam logic [15:0] OFS_AUTO_HALT  = 16'hFEC9;
   localparam logic [15:0] OFS_IO_INFO    = 16'hFEA4;
   localparam logic [15:0] OFS_IO_IP      = 16'hFE80;
   localparam logic [15:0] OFS_IO_COUNT   = 16'hFE88;
   localparam logic [15:0] OFS_IO_SRC     = 16'hFE90;
   localparam logic [15:0] OFS_IO_DST     = 16'hFE98;
   localparam logic [15:0] OFS_REVISION   = 16'hFEFC;

   // reset / entry values
   localparam logic [7:0]  IO_RESTART_CLEAR = 8'h00;
   localparam logic [7:0]  AUTO_HALT_CLEAR  = 8'h00;
   localparam logic [31:0] REVISION_BASE    = 32'h0000_0001; // arbitrary value
   localparam int          REV_IO_RESTART_BIT = 16;

   // restart information dword layout
   localparam int DW_TYPE     = 0;
   localparam int DW_VALID    = 1;
   localparam int DW_STRING   = 2;
   localparam int DW_REPEAT   = 3;
   localparam int DW_SIZE_LSB = 4;
   localparam int DW_ADDR_LSB = 7;
   localparam int DW_STEP     = 10;
   localparam int DW_BP_LSB   = 11;
   localparam int DW_PORT_LSB = 16;

   // configuration bit positions
   localparam int HWCFG_LOCK_BIT = 33;
   localparam int IDENT_LOCK_BIT = 3;
   localparam logic [3:0] CR_ZERO  = 4'h0;
   localparam logic [3:0] CR_THREE = 4'h3;
   localparam logic [3:0] CR_FOUR  = 4'h4;

   typedef struct packed {
      logic        is_io;
      logic        is_in;
      logic [15:0] port;
      logic        repeated_access_flag;
      logic        str;
      logic [2:0]  port_size;   // byte, word, dword one-hot
      logic [2:0]  addr_size;   // 16, 32, 64 one-hot
      logic [3:0]  bp_hit;
      logic        single_step;
   } mmr_io_info_s;

   typedef struct packed {
      logic [63:0] ip;
      logic [63:0] count;
      logic [63:0] src;
      logic [63:0] dst;
   } mmr_io_regs_s;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } mmr_sa_req_s;

   typedef enum logic [3:0] {
      ST_RUN    = 4'h1,
      ST_ENTER  = 4'h2,
      ST_INMODE = 4'h4,
      ST_EXIT   = 4'h8
   } mmr_state_e;

endpackage
`default_nettype wire

// file: hw/mmr_io_capture.sv
`timescale 1ns/10ps
`default_nettype none
module mmr_io_capture (
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  sys_rst,
   // capture request
   input  wire logic                  capture,
   input  wire mmr_pkg::mmr_io_info_s info,
   input  wire mmr_pkg::mmr_io_regs_s regs_in,
   // saved image
   output logic [31:0]                info_dword,
   output mmr_pkg::mmr_io_regs_s      regs_out
);
   import mmr_pkg::*;

   logic [31:0]  dword_q, dword_d;
   mmr_io_regs_s regs_q, regs_d;

   always_comb begin
      dword_d = dword_q;
      regs_d  = regs_q;
      if (capture) begin
         dword_d = '0;
         regs_d  = '0;
         if (info.is_io) begin
            dword_d[DW_VALID]             = 1'b1;
            dword_d[DW_TYPE]              = info.is_in;
            dword_d[DW_PORT_LSB +: 16]    = info.port;
            dword_d[DW_REPEAT]            = info.repeated_access_flag;
            dword_d[DW_STRING]            = info.str;
            dword_d[DW_SIZE_LSB +: 3]     = info.port_size;
            dword_d[DW_ADDR_LSB +: 3]     = info.addr_size;
            dword_d[DW_BP_LSB +: 4]       = info.bp_hit;
            dword_d[DW_STEP]              = info.single_step;
            regs_d                        = regs_in;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         dword_q <= '0;
         regs_q  <= '0;
      end else begin
         dword_q <= dword_d;
         regs_q  <= regs_d;
      end
   end

   assign info_dword = dword_q;
   assign regs_out   = regs_q;

   valid_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
      capture |=> (info_dword[DW_VALID] == $past(info.is_io)) &&
                  (info_dword[DW_TYPE] == ($past(info.is_io) && $past(info.is_in))))
      else $error("restart dword valid or type flag wrong");

endmodule // mmr_io_capture
`default_nettype wire

// file: hw/mmr_paging_lock.sv
`timescale 1ns/10ps
`default_nettype none
module mmr_paging_lock #(
   parameter bit LOCK_SUPPORTED = 1'b1
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // mode state
   input  wire logic        in_mode,
   input  wire logic        resume_done,
   // register writes
   input  wire logic        hwcfg_wr,
   input  wire logic [63:0] hwcfg_wdata,
   input  wire logic        ext_feature_reg_wr,
   input  wire logic        cr_wr,
   input  wire logic [3:0]  cr_index,
   // floating point
   input  wire logic        fp_exc,
   input  wire logic        fp_masked,
   // results
   output logic             lock,
   output logic             gp_fault,
   output logic             fp_fault,
   output logic             ident_lock_bit
);
   import mmr_pkg::*;

   logic lock_q, lock_d;
   logic gp_q, gp_d;
   logic fp_q, fp_d;
   logic set_req;
   logic guarded_wr;

   always_comb begin
      set_req    = hwcfg_wr && hwcfg_wdata[HWCFG_LOCK_BIT];
      guarded_wr = ext_feature_reg_wr ||
                   (cr_wr && (cr_index == CR_ZERO || cr_index == CR_THREE || cr_index == CR_FOUR));
      lock_d = lock_q;
      if (resume_done)
         lock_d = 1'b0;
      else if (set_req && in_mode && LOCK_SUPPORTED)
         lock_d = 1'b1;
      // mode switches stay legal while unlocked
      gp_d = (set_req && !in_mode) ||
             (lock_q && guarded_wr);
      fp_d = fp_exc && !fp_masked;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         lock_q <= 1'b0;
         gp_q   <= 1'b0;
         fp_q   <= 1'b0;
      end else begin
         lock_q <= lock_d;
         gp_q   <= gp_d;
         fp_q   <= fp_d;
      end
   end

   assign lock           = lock_q;
   assign gp_fault       = gp_q;
   assign fp_fault       = fp_q;
   assign ident_lock_bit = LOCK_SUPPORTED;

   lock_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
      resume_done |=> !lock)
      else $error("lock survived resume");

   gp_locked_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (lock && ext_feature_reg_wr) |=> gp_fault)
      else $error("no fault on locked write");

   gp_outside_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (set_req && !in_mode) |=> gp_fault && !lock)
      else $error("lock set outside mode without fault");

   fp_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (fp_exc && fp_masked) |=> !fp_fault)
      else $error("masked fp exception faulted");

endmodule // mmr_paging_lock
`default_nettype wire

// file: verif/mmr_sys_model.sv
`timescale 1ns/10ps
`default_nettype none
module mmr_sys_model (
   // clock and capability
   input  wire logic                 mclk,
   input  wire logic                 paging_lock_support,
   // interrupt source
   output var logic                  mgmt_interrupt,
   output var logic                  cpu_halted,
   output var mmr_pkg::mmr_io_info_s io_info,
   output var mmr_pkg::mmr_io_regs_s io_regs,
   // handler software
   output var logic                  resume_instr,
   output var mmr_pkg::mmr_sa_req_s  sa_req,
   output var logic                  hwcfg_wr,
   output var logic [63:0]           hwcfg_wdata
);
   import mmr_pkg::*;

   initial begin
      mgmt_interrupt = 1'b0;
      cpu_halted     = 1'b0;
      io_info        = '0;
      io_regs        = '0;
      resume_instr   = 1'b0;
      sa_req         = '0;
      hwcfg_wr       = 1'b0;
      hwcfg_wdata    = '0;
   end

   task automatic step();
      @(posedge mclk);
      #1;
   endtask

   // state is only sampled at the take edge, so scramble it afterwards
   task automatic raise(input logic halted, input mmr_io_info_s info, input mmr_io_regs_s regs);
      step();
      mgmt_interrupt = 1'b1;
      cpu_halted     = halted;
      io_info        = info;
      io_regs        = regs;
      step();
      mgmt_interrupt = 1'b0;
      cpu_halted     = ~halted;
      io_info        = ~info;
      io_regs        = ~regs;
   endtask

   task automatic sa_op(input logic wr, input logic [15:0] addr, input logic [7:0] data);
      step();
      sa_req = '{1'b1, wr, addr, data};
      step();
      sa_req = '{1'b0, ~wr, ~addr, ~data};
   endtask

   task automatic resume();
      step();
      resume_instr = 1'b1;
      step();
      resume_instr = 1'b0;
   endtask

   // handler only sets the lock when the core reports support
   task automatic set_lock(input logic val);
      step();
      if (val && paging_lock_support !== 1'b1) begin
         return;
      end
      hwcfg_wr    = 1'b1;
      hwcfg_wdata = {30'h0, val, 33'h0};
      step();
      hwcfg_wr    = 1'b0;
      hwcfg_wdata = ~hwcfg_wdata;
   endtask
endmodule // mmr_sys_model
`default_nettype wire

// file: verif/mgmt_mode_restart_and_lock_test.sv
`timescale 1ns/10ps
`default_nettype none
module mgmt_mode_restart_and_lock_test;
   import mmr_pkg::*;

   logic         mclk, sys_rst, ext_feature_reg_wr, cr_wr, fp_exc, fp_masked;
   logic [3:0]   cr_index;
   logic         mgmt_interrupt, cpu_halted, resume_instr, hwcfg_wr;
   logic [63:0]  hwcfg_wdata, sa_rdata;
   mmr_io_info_s io_info;
   mmr_io_regs_s io_regs;
   mmr_sa_req_s  sa_req;
   logic         mgmt_mode, entry_pulse, resume_done, resume_halt, io_reexec, halt_cycle;
   logic         sa_rvalid, paging_cfg_lock, general_protection_fault, fp_fault, paging_lock_support;
   int           errors, checks_done;

   mmr_core i_dut (.mclk(mclk), .sys_rst(sys_rst), .mgmt_interrupt(mgmt_interrupt),
      .cpu_halted(cpu_halted), .io_info(io_info), .io_regs(io_regs), .resume_instr(resume_instr),
      .mgmt_mode(mgmt_mode), .entry_pulse(entry_pulse), .resume_done(resume_done),
      .resume_halt(resume_halt), .io_reexec(io_reexec), .halt_cycle(halt_cycle), .sa_req(sa_req),
      .sa_rdata(sa_rdata), .sa_rvalid(sa_rvalid), .hwcfg_wr(hwcfg_wr), .hwcfg_wdata(hwcfg_wdata),
      .ext_feature_reg_wr(ext_feature_reg_wr), .cr_wr(cr_wr), .cr_index(cr_index), .fp_exc(fp_exc), .fp_masked(fp_masked),
      .paging_cfg_lock(paging_cfg_lock), .general_protection_fault(general_protection_fault),
      .fp_fault(fp_fault), .paging_lock_support(paging_lock_support));

   mmr_sys_model i_sys (.mclk(mclk), .paging_lock_support(paging_lock_support),
      .mgmt_interrupt(mgmt_interrupt), .cpu_halted(cpu_halted), .io_info(io_info), .io_regs(io_regs),
      .resume_instr(resume_instr), .sa_req(sa_req), .hwcfg_wr(hwcfg_wr), .hwcfg_wdata(hwcfg_wdata));

   always #4 mclk = ~mclk;

   task automatic check(input string n, input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic rd(input logic [15:0] a, input logic [63:0] exp, input string n);
      i_sys.sa_op(1'b0, a, 8'h00);
      check("rvalid", sa_rvalid, 1'b1);
      check(n, sa_rdata, exp);
   endtask

   task automatic cfg_pulse(input logic ef, input logic cr, input logic [3:0] idx);
      i_sys.step();
      ext_feature_reg_wr  = ef;
      cr_wr    = cr;
      cr_index = idx;
      i_sys.step();
      ext_feature_reg_wr  = 1'b0;
      cr_wr    = 1'b0;
      cr_index = ~idx;
   endtask

   task automatic fp_pulse(input logic m);
      i_sys.step();
      fp_masked = m;
      fp_exc    = 1'b1;
      i_sys.step();
      fp_exc    = 1'b0;
   endtask

   task automatic idle_case();
      check("support", paging_lock_support, 1'b1);
      rd(OFS_REVISION, {32'h0, REVISION_BASE | (32'h1 << REV_IO_RESTART_BIT)}, "revision");
      rd(16'h0100, 64'h0, "unmapped");
      i_sys.sa_op(1'b1, OFS_AUTO_HALT, 8'h5A);
      rd(OFS_AUTO_HALT, 64'h0, "halt byte idle");
      i_sys.set_lock(1'b1);
      check("gp outside", general_protection_fault, 1'b1);
      check("lock outside", paging_cfg_lock, 1'b0);
      fp_pulse(1'b1);
      check("fp masked", fp_fault, 1'b0);
      fp_pulse(1'b0);
      check("fp open", fp_fault, 1'b1);
   endtask

   task automatic halt_case();
      i_sys.raise(1'b1, '0, '0);
      check("entry", entry_pulse, 1'b1);
      check("mode", mgmt_mode, 1'b1);
      rd(OFS_AUTO_HALT, 64'h1, "halt byte");
      rd(OFS_IO_RESTART, 64'h0, "io byte");
      rd(OFS_IO_INFO, 64'h0, "no io");
      i_sys.resume();
      check("done", resume_done, 1'b1);
      check("to halt", resume_halt, 1'b1);
      i_sys.step();
      check("halt cycle", halt_cycle, 1'b1);
      check("mode off", mgmt_mode, 1'b0);
   endtask

   task automatic io_case(input logic in_dir, input logic fl, input logic [2:0] psz, input logic [2:0] asz);
      mmr_io_info_s info;
      mmr_io_regs_s regs;
      logic [31:0]  dw;
      logic [15:0]  port;
      port = {8'hC1, 5'h0, psz};
      info = '{1'b1, in_dir, port, fl, fl, psz, asz, {fl, 1'b0, ~fl, 1'b1}, fl};
      regs = {{4{port}}, 64'h0000_0000_0000_00C0, 64'h8000_0000_0000_1000, 64'hFFFF_FFFF_0000_2000};
      dw = ({31'h0, in_dir} << DW_TYPE) | (32'h1 << DW_VALID) | ({31'h0, fl} << DW_STRING)
         | ({31'h0, fl} << DW_REPEAT) | ({29'h0, psz} << DW_SIZE_LSB) | ({29'h0, asz} << DW_ADDR_LSB)
         | ({31'h0, fl} << DW_STEP) | ({28'h0, info.bp_hit} << DW_BP_LSB) | ({16'h0, port} << DW_PORT_LSB);
      i_sys.raise(1'b0, info, regs);
      rd(OFS_IO_INFO, {32'h0, dw}, "io info");
      rd(OFS_IO_IP, regs.ip, "io ip");
      rd(OFS_IO_COUNT, regs.count, "io count");
      rd(OFS_IO_SRC, regs.src, "io src");
      rd(OFS_IO_DST, regs.dst, "io dst");
      rd(OFS_IO_RESTART, 64'h0, "io byte clr");
      rd(OFS_AUTO_HALT, 64'h0, "halt byte run");
      i_sys.sa_op(1'b1, OFS_IO_RESTART, {in_dir, 7'h00});
      rd(OFS_IO_RESTART, {56'h0, in_dir, 7'h00}, "io byte wr");
      i_sys.resume();
      check("reexec", io_reexec, in_dir);
      check("no halt", resume_halt, 1'b0);
      i_sys.step();
      check("no halt cycle", halt_cycle, 1'b0);
   endtask

   task automatic lock_case();
      int i;
      i_sys.raise(1'b0, '0, '0);
      cfg_pulse(1'b0, 1'b1, 4'h0);
      check("mode switch", general_protection_fault, 1'b0);
      i_sys.set_lock(1'b1);
      check("lock set", paging_cfg_lock, 1'b1);
      check("gp in mode", general_protection_fault, 1'b0);
      i_sys.set_lock(1'b0);
      check("lock held", paging_cfg_lock, 1'b1);
      cfg_pulse(1'b1, 1'b0, 4'h0);
      check("gp feature", general_protection_fault, 1'b1);
      for (i = 0; i < 5; i++) begin
         cfg_pulse(1'b0, 1'b1, 4'(i));
         check("gp ctrl", general_protection_fault, (i == 0 || i == 3 || i == 4));
      end
      i_sys.sa_op(1'b1, OFS_AUTO_HALT, 8'h80);
      i_sys.raise(1'b0, '0, '0);
      i_sys.resume();
      check("run to halt", resume_halt, 1'b1);
      check("lock at done", paging_cfg_lock, 1'b1);
      i_sys.step();
      check("lock cleared", paging_cfg_lock, 1'b0);
      check("halt cycle run", halt_cycle, 1'b1);
      i_sys.step();
      check("pending entry", entry_pulse, 1'b1);
      i_sys.resume();
      check("lock stays off", paging_cfg_lock, 1'b0);
      cfg_pulse(1'b1, 1'b0, 4'h0);
      check("gp unlocked", general_protection_fault, 1'b0);
   endtask

   initial begin
      mclk        = 1'b0;
      sys_rst     = 1'b1;
      ext_feature_reg_wr     = 1'b0;
      cr_wr       = 1'b0;
      cr_index    = 4'h0;
      fp_exc      = 1'b0;
      fp_masked   = 1'b0;
      errors      = 0;
      checks_done = 0;
      repeat (3) @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      idle_case();
      halt_case();
      io_case(1'b1, 1'b1, 3'b010, 3'b100);
      io_case(1'b0, 1'b0, 3'b001, 3'b010);
      io_case(1'b1, 1'b0, 3'b100, 3'b001);
      lock_case();
      complete_run();
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      $display("BAD watchdog expected finish seen hang");
      complete_run();
   end
endmodule // mgmt_mode_restart_and_lock_test
`default_nettype wire
